// File: core/stc_top.sv
// Command-level motion and status logic of a stepper controller.
// Assumes an analog stall comparator, current loop and parameter store
// outside; limit, stall and general inputs arrive asynchronously.
`timescale 1ns/1ps

// Notes on behaviour
// - Speed mode nonzero runs continuously; zero ramps down to stop.
// - Immediate stop halts without ramp and leaves speed mode.
// - Start and stop speeds default 600, refuse values below 65.
// - Step commands refused if start or stop speed exceeds maximum.
// - Current compensation factor, default 300, drives current loop.
// - Speed compensation factor, default 1250, shapes current waveform.
// - Freerun on ends motion, zeroes phase current, sets freerun flag.
// - Step commands discarded while freerun stays enabled.
// - Immediate stop keeps current on and sets no flag.
// - Stall trigger level, length and configuration each written apart.
// - Stall latches position; a read command returns it.
// - Stall clear resets the stall bit and drops the indicator.
// - An accepted step command clears a leftover stall flag.
// - Port read and write use the packed 12-bit field.
// - Port write changes the general output bits and the stall indicator.
// - Status one: busy, both stops, auto decay, stalled.
// - Status two: freerun, both arms, speed mode, direction, autorun.
// - Save command asks the store to keep parameters; use sparingly.
// - New bus address applies from the very next frame.
// - Standalone program runs from power-up while commands still served.
// - Program holds at most 100 instructions.
// - Rotate count 1 up to maximum; microstep only zero or powers of two 2 to 128.
// - Armed limit input low locks motor until its flag clears.
// - Step commands ignored while busy.
// - Stall configuration: enable, stop on stall, indicator on stall.
module stc_top
	import stc_pkg::*;
#(
	parameter int unsigned BIT_CYCLES = STC_BIT_CYCLES
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// Serial command line
	input  wire logic        uart_rx,
	output logic             uart_tx,
	// Motor drive
	output logic             step_pulse,
	output logic             step_direction,
	output logic             phase_current_on,
	output logic [7:0]       step_division,
	output logic [15:0]      current_comp_value,
	output logic [15:0]      speed_comp_value,
	// Stall sensing
	input  wire logic        stall_sense,
	output logic [8:0]       stall_trigger_level,
	output logic [5:0]       stall_length,
	output logic             stall_indicator_output,
	// Limit stops and general ports
	input  wire logic        first_limit_stop,
	input  wire logic        second_limit_stop,
	input  wire logic [4:0]  general_input,
	output logic [3:0]       general_output,
	// Parameter store and program engine
	output logic             save_request,
	input  wire logic        autorun_strap,
	input  wire logic        program_advance,
	output logic             program_running,
	output logic [6:0]       program_index
);
	import stc_pkg::*;

	function automatic logic div_ok(input logic [31:0] v);
		div_ok = (v == 32'h0) || (v >= 32'h2 && v <= {24'h0, STC_MICRO_MAX}
			&& (v & (v - 32'h1)) == 32'h0);
	endfunction : div_ok

	logic [7:0]  rx_byte;
	logic        rx_valid;
	logic        tx_ready;
	logic [8:0]  meta_reg;
	logic [8:0]  sync_reg;
	logic [7:0]  frame_reg [0:7];
	logic [2:0]  idx_reg;
	logic        frame_done_reg;
	logic [7:0]  addr_reg;
	logic        tx_active_reg;
	logic [2:0]  tx_cnt_reg;
	logic [7:0]  rep_addr_reg;
	logic [31:0] rep_data_reg;
	stc_motion_t state_reg;
	logic [31:0] steps_left_reg;
	logic [26:0] acc_reg;
	logic signed [31:0] pos_reg;
	logic [31:0] stall_pos_reg;
	logic [15:0] start_spd_reg;
	logic [15:0] stop_spd_reg;
	logic [15:0] max_spd_reg;
	logic [15:0] run_spd_reg;
	logic [2:0]  stall_cfg_reg;
	logic        freerun_reg;
	logic        arm1_reg;
	logic        arm2_reg;
	logic        first_limit_stop_flag_reg;
	logic        second_limit_stop_flag_reg;
	logic        stall_flag_reg;
	logic        decay_en_reg;
	logic        autorun_reg;
	logic [1:0]  boot_cnt_reg;

	logic [7:0]  sum;
	logic        cmd_valid;
	logic [7:0]  op;
	logic [31:0] data;
	logic        busy;
	logic        step_ok;
	logic        step_take;
	logic        speed_take;
	logic        first_limit_stop_trip;
	logic        second_limit_stop_trip;
	logic        stall_evt;
	logic        halt;
	logic [26:0] acc_sum;
	logic        tick;
	logic [4:0]  status1;
	logic [5:0]  status2;
	logic [11:0] port_word;
	logic [31:0] rdata;
	logic [7:0]  tx_byte;
	logic [7:0]  rep_sum;

	stc_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
		.clock      (clock),
		.reset      (reset),
		.rx_pin     (uart_rx),
		.byte_data  (rx_byte),
		.byte_valid (rx_valid)
	);

	stc_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
		.clock      (clock),
		.reset      (reset),
		.byte_in    (tx_byte),
		.byte_valid (tx_active_reg),
		.byte_ready (tx_ready),
		.tx_pin     (uart_tx)
	);

	// Two-flop synchronisers: {strap, stall, limit2, limit1, inputs}
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			meta_reg <= 9'h07f;
			sync_reg <= 9'h07f;
		end
		else
		begin
			meta_reg <= {autorun_strap, stall_sense, second_limit_stop,
				first_limit_stop, general_input};
			sync_reg <= meta_reg;
		end
	end

	// Frame assembly; a wrong header byte resynchronises
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			idx_reg        <= 3'h0;
			frame_done_reg <= 1'b0;
			for (int i = 0; i < 8; i++)
				frame_reg[i] <= 8'h00;
		end
		else
		begin
			frame_done_reg <= 1'b0;
			if (rx_valid && (idx_reg != 3'h0 || rx_byte == STC_HDR))
			begin
				frame_reg[idx_reg] <= rx_byte;
				idx_reg            <= idx_reg + 3'h1;
				frame_done_reg     <= (idx_reg == STC_FRAME_LAST);
			end
		end
	end

	always_comb
	begin
		sum = 8'h00;
		for (int i = 0; i < 7; i++)
			sum = sum + frame_reg[i];
	end

	assign op   = frame_reg[2];
	assign data = {frame_reg[6], frame_reg[5], frame_reg[4], frame_reg[3]};
	// Frames arriving mid-reply are dropped: host waits for each answer
	assign cmd_valid = frame_done_reg && sum == frame_reg[7] &&
		frame_reg[1] == addr_reg && !tx_active_reg;

	assign busy = (state_reg != STC_IDLE);
	assign step_ok = !busy && !freerun_reg && !first_limit_stop_flag_reg
		&& !second_limit_stop_flag_reg && start_spd_reg <= max_spd_reg
		&& stop_spd_reg <= max_spd_reg;
	assign step_take = cmd_valid && op == STC_OP_STEP && step_ok &&
		data != 32'h0 && data <= STC_ROT_MAX;
	assign speed_take = cmd_valid && op == STC_OP_SPEED_MODE &&
		data != 32'h0 && !freerun_reg && !first_limit_stop_flag_reg && !second_limit_stop_flag_reg;
	assign first_limit_stop_trip = arm1_reg && !sync_reg[5];
	assign second_limit_stop_trip = arm2_reg && !sync_reg[6];
	assign stall_evt = stall_cfg_reg[STC_CFG_EN] && sync_reg[7] && busy;
	assign halt = (cmd_valid && op == STC_OP_STOP)
		|| (cmd_valid && op == STC_OP_FREERUN && data != 32'h0)
		|| first_limit_stop_trip || second_limit_stop_trip
		|| (stall_evt && stall_cfg_reg[STC_CFG_STOP]);

	// Rate generator: one-cycle step enable at run_spd_reg pulses/s
	assign acc_sum = acc_reg + {11'h000, run_spd_reg};
	assign tick    = busy && acc_sum >= STC_CLK_HZ_W;

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			acc_reg <= 27'h0;
		else if (!busy)
			acc_reg <= 27'h0;
		else if (tick)
			acc_reg <= acc_sum - STC_CLK_HZ_W;
		else
			acc_reg <= acc_sum;
	end

	// Motion state
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state_reg      <= STC_IDLE;
			steps_left_reg <= 32'h0;
			run_spd_reg    <= 16'h0;
			step_pulse     <= 1'b0;
			pos_reg        <= 32'sh0;
		end
		else
		begin
			step_pulse <= 1'b0;
			if (halt)
				state_reg <= STC_IDLE;
			else
			begin
				case (state_reg)
				STC_IDLE:
					if (step_take)
					begin
						state_reg      <= STC_STEP;
						steps_left_reg <= data;
						run_spd_reg    <= max_spd_reg;
					end
					else if (speed_take)
					begin
						state_reg   <= STC_SPEED;
						run_spd_reg <= data[15:0];
					end
				STC_SPEED:
					if (cmd_valid && op == STC_OP_SPEED_MODE)
					begin
						if (data == 32'h0)
						begin
							state_reg      <= STC_DECEL;
							steps_left_reg <= STC_DECEL_STEPS;
							run_spd_reg    <= stop_spd_reg;
						end
						else
							run_spd_reg <= data[15:0];
					end
				STC_STEP, STC_DECEL:
					if (tick && steps_left_reg == 32'h1)
						state_reg <= STC_IDLE;
				default:
					state_reg <= STC_IDLE;
				endcase
				if (tick)
				begin
					step_pulse <= 1'b1;
					pos_reg    <= step_direction ? pos_reg + 32'sh1
						: pos_reg - 32'sh1;
					if (state_reg != STC_SPEED)
						steps_left_reg <= steps_left_reg - 32'h1;
				end
			end
		end
	end

	// Status flags; a setting event wins over a clear in the same cycle
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			first_limit_stop_flag_reg          <= 1'b0;
			second_limit_stop_flag_reg          <= 1'b0;
			stall_flag_reg         <= 1'b0;
			stall_indicator_output <= 1'b0;
			stall_pos_reg          <= 32'h0;
		end
		else
		begin
			if (first_limit_stop_trip)
				first_limit_stop_flag_reg <= 1'b1;
			else if (cmd_valid && op == STC_OP_FIRST_LIMIT_STOP_CLR)
				first_limit_stop_flag_reg <= 1'b0;
			if (second_limit_stop_trip)
				second_limit_stop_flag_reg <= 1'b1;
			else if (cmd_valid && op == STC_OP_SECOND_LIMIT_STOP_CLR)
				second_limit_stop_flag_reg <= 1'b0;
			if (stall_evt)
			begin
				stall_flag_reg <= 1'b1;
				stall_pos_reg  <= pos_reg;
			end
			else if ((cmd_valid && op == STC_OP_STALL_CLR) || step_take)
				stall_flag_reg <= 1'b0;
			if (stall_evt && stall_cfg_reg[STC_CFG_IND])
				stall_indicator_output <= 1'b1;
			else if (cmd_valid && op == STC_OP_STALL_CLR)
				stall_indicator_output <= 1'b0;
			else if (cmd_valid && op == STC_OP_PORT_WR)
				stall_indicator_output <= data[7];
		end
	end

	// Settings written by command
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			addr_reg            <= STC_ADDR_RST;
			start_spd_reg       <= STC_EDGE_SPD_RST;
			stop_spd_reg        <= STC_EDGE_SPD_RST;
			max_spd_reg         <= STC_MAX_SPD_RST;
			current_comp_value  <= STC_CUR_COMP_RST;
			speed_comp_value    <= STC_SPD_COMP_RST;
			stall_trigger_level <= 9'h000;
			stall_length        <= 6'h00;
			stall_cfg_reg       <= 3'h0;
			freerun_reg         <= 1'b0;
			phase_current_on    <= 1'b1;
			arm1_reg            <= 1'b0;
			arm2_reg            <= 1'b0;
			step_direction      <= 1'b1;
			decay_en_reg        <= 1'b0;
			step_division       <= STC_MICRO_RST;
			general_output      <= 4'h0;
			save_request        <= 1'b0;
		end
		else
		begin
			save_request     <= cmd_valid && op == STC_OP_SAVE;
			phase_current_on <= !freerun_reg;
			if (cmd_valid)
			begin
				case (op)
				STC_OP_ADDR:
					addr_reg <= data[7:0];
				STC_OP_START_SPD:
					if (data[15:0] >= STC_MIN_SPD && data[31:16] == 16'h0)
						start_spd_reg <= data[15:0];
				STC_OP_STOP_SPD:
					if (data[15:0] >= STC_MIN_SPD && data[31:16] == 16'h0)
						stop_spd_reg <= data[15:0];
				STC_OP_MAX_SPD:
					max_spd_reg <= data[15:0];
				STC_OP_CUR_COMP:
					current_comp_value <= data[15:0];
				STC_OP_SPD_COMP:
					speed_comp_value <= data[15:0];
				STC_OP_STALL_TRIG:
					stall_trigger_level <= data[8:0];
				STC_OP_STALL_LEN:
					stall_length <= data[5:0];
				STC_OP_STALL_CFG:
					stall_cfg_reg <= data[2:0];
				STC_OP_FREERUN:
					freerun_reg <= (data != 32'h0);
				STC_OP_EXT_ARM:
				begin
					arm1_reg <= data[0];
					arm2_reg <= data[1];
				end
				STC_OP_DIR:
					if (!busy)
						step_direction <= data[0];
				STC_OP_AUTO_DECAY:
					decay_en_reg <= data[0];
				STC_OP_MICROSTEP:
					if (div_ok(data))
						step_division <= data[7:0];
				STC_OP_PORT_WR:
					general_output <= data[6:3];
				default:
					;
				endcase
			end
		end
	end

	// Standalone program: strap caught after release, index below 100
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			boot_cnt_reg    <= 2'h0;
			autorun_reg     <= 1'b0;
			program_running <= 1'b0;
			program_index   <= 7'h00;
		end
		else
		begin
			if (boot_cnt_reg != 2'h3)
				boot_cnt_reg <= boot_cnt_reg + 2'h1;
			if (boot_cnt_reg == 2'h2)
			begin
				autorun_reg     <= sync_reg[8];
				program_running <= sync_reg[8];
			end
			else if (cmd_valid && op == STC_OP_AUTORUN)
				autorun_reg <= data[0];
			if (program_running && program_advance)
				program_index <= (program_index == STC_PROG_MAX - 7'h1)
					? 7'h00 : program_index + 7'h1;
		end
	end

	assign status1 = {stall_flag_reg, decay_en_reg && !busy,
		second_limit_stop_flag_reg, first_limit_stop_flag_reg, busy};
	assign status2 = {autorun_reg, step_direction,
		state_reg == STC_SPEED, arm2_reg, arm1_reg, freerun_reg};
	assign port_word = {sync_reg[6], sync_reg[5], sync_reg[4],
		sync_reg[3], stall_indicator_output, general_output, sync_reg[2:0]};

	always_comb
	begin
		case (op)
		STC_OP_STATUS2:   rdata = {26'h0, status2};
		STC_OP_STALL_POS: rdata = stall_pos_reg;
		STC_OP_PORT_RD:   rdata = {20'h0, port_word};
		STC_OP_STALL_CFG: rdata = {29'h0, stall_cfg_reg};
		STC_OP_STALL_LEN: rdata = {26'h0, stall_length};
		STC_OP_STALL_TRIG: rdata = {23'h0, stall_trigger_level};
		default:          rdata = {27'h0, status1};
		endcase
	end

	// Reply: a5 7a addr d0 d1 d2 d3 checksum
	assign rep_sum = STC_HDR + STC_REPLY_TAG + rep_addr_reg +
		rep_data_reg[7:0] + rep_data_reg[15:8] + rep_data_reg[23:16] +
		rep_data_reg[31:24];

	always_comb
	begin
		case (tx_cnt_reg)
		3'h0:    tx_byte = STC_HDR;
		3'h1:    tx_byte = STC_REPLY_TAG;
		3'h2:    tx_byte = rep_addr_reg;
		3'h3:    tx_byte = rep_data_reg[7:0];
		3'h4:    tx_byte = rep_data_reg[15:8];
		3'h5:    tx_byte = rep_data_reg[23:16];
		3'h6:    tx_byte = rep_data_reg[31:24];
		default: tx_byte = rep_sum;
		endcase
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			tx_active_reg <= 1'b0;
			tx_cnt_reg    <= 3'h0;
			rep_addr_reg  <= 8'h00;
			rep_data_reg  <= 32'h0;
		end
		else if (cmd_valid)
		begin
			tx_active_reg <= 1'b1;
			tx_cnt_reg    <= 3'h0;
			rep_addr_reg  <= frame_reg[1];
			rep_data_reg  <= rdata;
		end
		else if (tx_active_reg && tx_ready)
		begin
			tx_cnt_reg <= tx_cnt_reg + 3'h1;
			if (tx_cnt_reg == STC_FRAME_LAST)
				tx_active_reg <= 1'b0;
		end
	end
endmodule : stc_top

// File: core/stc_uart_rx.sv
// Serial byte receiver, 8N1, for the command line.
// Assumes the line idles high; the pin is synchronised here.
`timescale 1ns/1ps
module stc_uart_rx #(
	parameter int unsigned BIT_CYCLES = 10416
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Line
	input  wire logic       rx_pin,
	// Received byte
	output logic [7:0]      byte_data,
	output logic            byte_valid
);
	logic        meta_reg;
	logic        line_reg;
	logic        active_reg;
	logic [15:0] cnt_reg;
	logic [3:0]  bit_reg;
	logic [7:0]  shift_reg;

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			meta_reg <= 1'b1;
			line_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= rx_pin;
			line_reg <= meta_reg;
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			active_reg <= 1'b0;
			cnt_reg    <= 16'h0000;
			bit_reg    <= 4'h0;
			shift_reg  <= 8'h00;
			byte_data  <= 8'h00;
			byte_valid <= 1'b0;
		end
		else
		begin
			byte_valid <= 1'b0;
			if (!active_reg)
			begin
				// Start with a half bit so samples sit mid-bit
				if (!line_reg)
				begin
					active_reg <= 1'b1;
					cnt_reg    <= 16'(BIT_CYCLES / 2);
					bit_reg    <= 4'h0;
				end
			end
			else if (cnt_reg != 16'h0000)
				cnt_reg <= cnt_reg - 16'h0001;
			else
			begin
				cnt_reg <= 16'(BIT_CYCLES - 1);
				bit_reg <= bit_reg + 4'h1;
				if (bit_reg == 4'h0 && line_reg)
					active_reg <= 1'b0;
				else if (bit_reg == 4'h9)
				begin
					active_reg <= 1'b0;
					byte_data  <= shift_reg;
					byte_valid <= line_reg;
				end
				else if (bit_reg != 4'h0)
					shift_reg <= {line_reg, shift_reg[7:1]};
			end
		end
	end
endmodule : stc_uart_rx

// File: core/stc_uart_tx.sv
// Serial byte transmitter, 8N1, for reply frames.
// Assumes the caller holds byte_valid until byte_ready accepts it.
`timescale 1ns/1ps
module stc_uart_tx #(
	parameter int unsigned BIT_CYCLES = 10416
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Byte to send
	input  wire logic [7:0] byte_in,
	input  wire logic       byte_valid,
	output logic            byte_ready,
	// Line
	output logic            tx_pin
);
	logic [15:0] cnt_reg;
	logic [3:0]  bit_reg;
	logic [8:0]  shift_reg;

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			byte_ready <= 1'b1;
			tx_pin     <= 1'b1;
			cnt_reg    <= 16'h0000;
			bit_reg    <= 4'h0;
			shift_reg  <= 9'h1ff;
		end
		else if (byte_ready)
		begin
			if (byte_valid)
			begin
				byte_ready <= 1'b0;
				tx_pin     <= 1'b0;
				shift_reg  <= {1'b1, byte_in};
				cnt_reg    <= 16'(BIT_CYCLES - 1);
				bit_reg    <= 4'h0;
			end
		end
		else if (cnt_reg != 16'h0000)
			cnt_reg <= cnt_reg - 16'h0001;
		else if (bit_reg == 4'h9)
			byte_ready <= 1'b1;
		else
		begin
			tx_pin    <= shift_reg[0];
			shift_reg <= {1'b1, shift_reg[8:1]};
			bit_reg   <= bit_reg + 4'h1;
			cnt_reg   <= 16'(BIT_CYCLES - 1);
		end
	end
endmodule : stc_uart_tx

// File: inc/stc_pkg.sv
// Shared constants for the stepper command controller.
// Assumes a 100 MHz core clock and 8N1 serial command frames.
package stc_pkg;
	localparam int unsigned STC_CLK_HZ     = 100_000_000;
	localparam int unsigned STC_BAUD_HZ    = 9600;
	localparam int unsigned STC_BIT_CYCLES = STC_CLK_HZ / STC_BAUD_HZ;
	localparam logic [26:0] STC_CLK_HZ_W   = 27'h5f5e100;

	// Frame layout
	localparam logic [2:0] STC_FRAME_LAST = 3'h7;
	localparam logic [7:0] STC_HDR        = 8'ha5;
	localparam logic [7:0] STC_REPLY_TAG  = 8'h7a;

	// Opcodes
	localparam logic [7:0] STC_OP_STOP       = 8'h49;
	localparam logic [7:0] STC_OP_START_SPD  = 8'h4c;
	localparam logic [7:0] STC_OP_STOP_SPD   = 8'h53;
	localparam logic [7:0] STC_OP_CUR_COMP   = 8'h4d;
	localparam logic [7:0] STC_OP_SPD_COMP   = 8'h50;
	localparam logic [7:0] STC_OP_FREERUN    = 8'h67;
	localparam logic [7:0] STC_OP_STALL_TRIG = 8'h5a;
	localparam logic [7:0] STC_OP_STALL_LEN  = 8'h54;
	localparam logic [7:0] STC_OP_STALL_CFG  = 8'h59;
	localparam logic [7:0] STC_OP_STALL_POS  = 8'h58;
	localparam logic [7:0] STC_OP_STALL_CLR  = 8'h70;
	localparam logic [7:0] STC_OP_PORT_RD    = 8'h78;
	localparam logic [7:0] STC_OP_PORT_WR    = 8'h79;
	localparam logic [7:0] STC_OP_STATUS1    = 8'h6a;
	localparam logic [7:0] STC_OP_STATUS2    = 8'h4f;
	localparam logic [7:0] STC_OP_SAVE       = 8'h74;
	localparam logic [7:0] STC_OP_STEP       = 8'h73;
	localparam logic [7:0] STC_OP_FIRST_LIMIT_STOP_CLR   = 8'h62;
	localparam logic [7:0] STC_OP_SECOND_LIMIT_STOP_CLR   = 8'h6c;
	localparam logic [7:0] STC_OP_MICROSTEP  = 8'h6d;
	localparam logic [7:0] STC_OP_SPEED_MODE = 8'h60;
	localparam logic [7:0] STC_OP_MAX_SPD    = 8'h56;
	localparam logic [7:0] STC_OP_EXT_ARM    = 8'h6b;
	localparam logic [7:0] STC_OP_DIR        = 8'h64;
	localparam logic [7:0] STC_OP_ADDR       = 8'h41;
	localparam logic [7:0] STC_OP_AUTO_DECAY = 8'h57;
	localparam logic [7:0] STC_OP_AUTORUN    = 8'h44;

	// Reset values and limits
	localparam logic [7:0]  STC_ADDR_RST      = 8'h01;
	localparam logic [15:0] STC_EDGE_SPD_RST  = 16'h0258;
	localparam logic [15:0] STC_MIN_SPD       = 16'h0041;
	localparam logic [15:0] STC_MAX_SPD_RST   = 16'h0bb8;
	localparam logic [15:0] STC_CUR_COMP_RST  = 16'h012c;
	localparam logic [15:0] STC_SPD_COMP_RST  = 16'h04e2;
	localparam logic [7:0]  STC_MICRO_RST     = 8'h10;
	localparam logic [7:0]  STC_MICRO_MAX     = 8'h80;
	localparam logic [6:0]  STC_PROG_MAX      = 7'h64;
	localparam logic [31:0] STC_ROT_MAX       = 32'h7fffffff;
	localparam logic [31:0] STC_DECEL_STEPS   = 32'h00000010;

	// Status word bit positions
	localparam int STC_S1_BUSY  = 0;
	localparam int STC_S1_FIRST_LIMIT_STOP  = 1;
	localparam int STC_S1_SECOND_LIMIT_STOP  = 2;
	localparam int STC_S1_DECAY = 3;
	localparam int STC_S1_STALL = 4;
	localparam int STC_S2_FREE  = 0;
	localparam int STC_S2_ARM1  = 1;
	localparam int STC_S2_ARM2  = 2;
	localparam int STC_S2_SPEED = 3;
	localparam int STC_S2_DIR   = 4;
	localparam int STC_S2_AUTO  = 5;

	// Stall configuration bits
	localparam int STC_CFG_EN   = 0;
	localparam int STC_CFG_STOP = 1;
	localparam int STC_CFG_IND  = 2;

	typedef enum logic [1:0] {STC_IDLE, STC_STEP, STC_SPEED, STC_DECEL}
		stc_motion_t;
endpackage : stc_pkg

// File: verif/stc_assertions.sv
// Port checker for stc_top, attached by bind.
// Assumes one clock and an active-high reset.
`timescale 1ns/1ps
module stc_chk #(parameter int unsigned BIT_CYCLES = 8) (
	input wire logic        clock, reset, uart_tx, step_pulse,
	input wire logic        phase_current_on, save_request,
	input wire logic [7:0]  step_division,
	input wire logic [15:0] current_comp_value,
	input wire logic [3:0]  general_output,
	input wire logic [6:0]  program_index
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	// Start bit plus eight zero bits is the longest low run
	int unsigned low_reg;
	always_ff @(posedge clock or posedge reset)
		if (reset)
			low_reg <= '0;
		else
			low_reg <= uart_tx ? '0 : low_reg + 1;
	property p_pulse; step_pulse |=> !step_pulse; endproperty
	a_pulse: assert property (p_pulse) else $error("wide step");
	property p_free; !phase_current_on |-> !step_pulse; endproperty
	a_free: assert property (p_free) else $error("step released");
	property p_div;
		$onehot0(step_division) && step_division != 8'h01;
	endproperty
	a_div: assert property (p_div) else $error("bad division");
	property p_prog; program_index < 7'h64; endproperty
	a_prog: assert property (p_prog) else $error("index range");
	property p_crst; $fell(reset) |-> current_comp_value == 16'h012c;
	endproperty
	a_crst: assert property (p_crst) else $error("comp reset");
	property p_port; $changed(general_output) |-> ##[0:8] !uart_tx;
	endproperty
	a_port: assert property (p_port) else $error("stray output");
	property p_save; save_request |=> !save_request ##[0:8] !uart_tx;
	endproperty
	a_save: assert property (p_save) else $error("save pulse");
	property p_tx; low_reg <= 9 * BIT_CYCLES; endproperty
	a_tx: assert property (p_tx) else $error("line low");
	c_step: cover property (step_pulse);
	c_free: cover property (!phase_current_on);
	c_save: cover property (save_request);
endmodule : stc_chk

bind stc_top stc_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.clock, .reset,
	.uart_tx, .step_pulse, .phase_current_on, .save_request,
	.step_division, .current_comp_value, .general_output, .program_index);

// File: verif/stc_host.sv
// Serial host model: sends command frames and collects the replies.
// Assumes 8N1 at BIT clocks per bit; drives on the falling edge.
`timescale 1ns/1ps
module stc_host #(
	parameter int unsigned BIT = 8
) (
	input  wire logic clock,
	output logic      rx,
	input  wire logic tx
);
	initial rx = 1'b1;

	task automatic put(input logic [7:0] b, input int nb);
		for (int i = 0; i < nb; i++)
		begin
			rx = 1'({1'b1, b, 1'b0} >> i);
			repeat (BIT) @(negedge clock);
		end
	endtask : put

	task automatic get(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		while (tx === 1'b1 && n < 4000)
		begin
			@(negedge clock);
			n++;
		end
		ok = (tx === 1'b0);
		repeat (BIT / 2) @(negedge clock);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(negedge clock);
			b[i] = tx;
		end
		repeat (BIT) @(negedge clock);
	endtask : get

	// Last stop bit is left to idle so an early reply start is not missed
	task automatic frame(input logic [7:0] a, op, input logic [31:0] d,
		output logic [31:0] r, output logic ok);
		logic [7:0] f[8];
		logic k;
		f = '{8'ha5, a, op, d[7:0], d[15:8], d[23:16], d[31:24], 8'h00};
		for (int i = 0; i < 7; i++) f[7] += f[i];
		for (int i = 0; i < 8; i++) put(f[i], i < 7 ? 10 : 9);
		rx = 1'b1;
		ok = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			get(f[i], k);
			ok &= k;
		end
		r = {f[6], f[5], f[4], f[3]};
		k = (f[0] == 8'ha5) && (f[1] == 8'h7a) && (f[2] == a);
		for (int i = 0; i < 7; i++) f[7] -= f[i];
		ok &= k && (f[7] == 8'h00);
	endtask : frame
endmodule : stc_host

// File: verif/tb.sv
// Bench for stc_top: host model sends frames; ports and replies judged.
// Assumes the bound checker and a short bit time.
`timescale 1ns/1ps
module tb;
	logic clock = 0, reset = 1, uart_rx, uart_tx, step_pulse, step_direction;
	logic phase_current_on, stall_indicator_output, save_request;
	logic program_running, first_limit_stop = 1, stall_sense = 0;
	logic [7:0] step_division;
	logic [15:0] current_comp_value, speed_comp_value;
	logic [8:0] stall_trigger_level;
	logic [5:0] stall_length;
	logic [4:0] general_input = 5'h15;
	logic [3:0] general_output;
	logic [6:0] program_index;
	logic [31:0] r;
	int pulses = 0, n_mismatch = 0, checks = 0, b, saves = 0;
	always #5 clock = ~clock;
	always @(posedge clock) pulses <= pulses + int'(step_pulse === 1'b1);
	always @(posedge clock) saves <= saves + int'(save_request === 1'b1);
	stc_top #(.BIT_CYCLES(8)) u_dut (.clock, .reset, .uart_rx, .uart_tx,
		.step_pulse, .step_direction, .phase_current_on, .step_division,
		.current_comp_value, .speed_comp_value, .stall_sense,
		.stall_trigger_level, .stall_length, .stall_indicator_output,
		.first_limit_stop, .second_limit_stop(1'b1), .general_input,
		.general_output, .save_request, .autorun_strap(1'b0),
		.program_advance(1'b0), .program_running, .program_index);
	stc_host u_host (.clock, .rx(uart_rx), .tx(uart_tx));

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic c(logic [7:0] op, logic [31:0] d);
		logic ok;
		u_host.frame(8'h01, op, d, r, ok);
		chk("reply", 1, ok);
	endtask : c
	task automatic wp(int n, int lim);
		for (int i = 0; i < lim && pulses < n; i++) @(negedge clock);
	endtask : wp
	task automatic results;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	task automatic t_set;
		chk("div", 8'h10, step_division);
		chk("ccomp", 16'h012c, current_comp_value);
		chk("scomp", 16'h04e2, speed_comp_value);
		c(8'h4d, 200);
		chk("ccomp", 200, current_comp_value);
		c(8'h50, 512);
		chk("scomp", 512, speed_comp_value);
		// Issued once only: the store wears out
		c(8'h74, 0);
		chk("save", 1, saves);
		$display("test settings done");
	endtask : t_set
	task automatic t_port;
		c(8'h79, 32'hfff);
		chk("gpo", 4'hf, general_output);
		chk("ind", 1, stall_indicator_output);
		c(8'h79, 32'h010);
		chk("gpo", 4'h2, general_output);
		first_limit_stop = 0;
		general_input = 5'h0a;
		c(8'h78, 0);
		chk("port", 32'h912, r);
		first_limit_stop = 1;
		$display("test port done");
	endtask : t_port
	task automatic t_lim;
		c(8'h56, 100);
		c(8'h53, 65);
		c(8'h4c, 64);
		b = pulses;
		c(8'h73, 3);
		wp(b + 1, 3000);
		chk("refused", b, pulses);
		c(8'h6a, 0);
		chk("busy", 0, r[0]);
		c(8'h56, 20000);
		c(8'h73, 3);
		c(8'h73, 3);
		wp(b + 4, 20000);
		chk("steps", b + 3, pulses);
		$display("test limits done");
	endtask : t_lim
	task automatic t_free;
		b = pulses;
		c(8'h73, 3);
		wp(b + 1, 6000);
		c(8'h67, 1);
		chk("current", 0, phase_current_on);
		c(8'h4f, 0);
		chk("free flag", 1, r[0]);
		b = pulses;
		c(8'h73, 3);
		wp(b + 1, 6000);
		chk("discard", b, pulses);
		c(8'h67, 0);
		chk("current", 1, phase_current_on);
		$display("test freerun done");
	endtask : t_free
	task automatic t_speed;
		c(8'h60, 20000);
		c(8'h4f, 0);
		chk("speed flag", 1, r[3]);
		chk("dir", 1, r[4]);
		b = pulses;
		wp(b + 1, 6000);
		chk("running", 1, pulses > b);
		c(8'h60, 0);
		c(8'h4f, 0);
		chk("speed flag", 0, r[3]);
		c(8'h49, 0);
		c(8'h6a, 0);
		chk("busy", 0, r[0]);
		chk("current", 1, phase_current_on);
		b = pulses;
		c(8'h73, 1);
		wp(b + 2, 8000);
		chk("next step", b + 1, pulses);
		$display("test speed done");
	endtask : t_speed
	task automatic t_stall;
		c(8'h59, 7);
		c(8'h73, 5);
		stall_sense = 1;
		c(8'h58, 0);
		chk("stall pos", pulses, r);
		chk("ind", 1, stall_indicator_output);
		c(8'h70, 0);
		chk("stall flag", 1, r[4]);
		chk("ind", 0, stall_indicator_output);
		stall_sense = 0;
		$display("test stall done");
	endtask : t_stall

	initial
	begin
		repeat (100000) @(posedge clock);
		n_mismatch++;
		results;
	end
	initial
	begin
		repeat (20) @(negedge clock);
		reset = 0;
		repeat (4) @(negedge clock);
		t_set;
		t_port;
		t_lim;
		t_free;
		t_speed;
		t_stall;
		results;
	end
endmodule : tb
